// >>> verilog/vrs_supervisor.sv
// module: setpoint shaping, lockout, sensing loss and over-excitation supervision
`default_nettype none
module vrs_supervisor #(
  parameter int TICK_CYCLES = vrs_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // measurements from the converter on this clock: 0.1 % of rated, except freqHz in Hz and engineRpm in rpm
  input  wire logic signed [15:0] kvarPct,
  input  wire logic        [15:0] vllAvgPct,
  input  wire logic        [15:0] vllA,
  input  wire logic        [15:0] vllB,
  input  wire logic        [15:0] vllC,
  input  wire logic        [15:0] vlnA,
  input  wire logic        [15:0] vlnB,
  input  wire logic        [15:0] vlnC,
  input  wire logic        [15:0] iA,
  input  wire logic        [15:0] iB,
  input  wire logic        [15:0] iC,
  input  wire logic        [15:0] freqHz,
  input  wire logic        [15:0] engineRpm,
  // regulation loop
  input  wire logic        [7:0]  loopExcPct,
  input  wire vrs_pkg::vrs_mode_e opMode,
  input  wire logic               threePhase,
  // operator inputs, asynchronous pins
  input  wire logic               raisePin,
  input  wire logic               lowerPin,
  input  wire logic               keyRaise,
  input  wire logic               keyLower,
  // configuration
  input  wire logic        [15:0] maxDroopPct,
  input  wire logic        [15:0] maxBiasPct,
  input  wire logic        [15:0] minFreqHz,
  input  wire logic        [7:0]  losDelayCfg,
  input  wire logic        [7:0]  ovxThrCfg,
  input  wire logic        [7:0]  ovxDelayCfg,
  input  wire logic               lockoutReq,
  input  wire logic               setStopped,
  input  wire logic signed [15:0] anaSig,
  input  wire logic signed [15:0] anaSigLo,
  input  wire logic signed [15:0] anaSigHi,
  input  wire logic signed [15:0] anaDatLo,
  input  wire logic signed [15:0] anaDatHi,
  input  wire logic signed [15:0] compBiasPct,
  input  wire logic               eventReset,
  // outputs
  output logic signed [15:0]      setpointPct,
  output logic signed [15:0]      totalBiasPct,
  output logic signed [15:0]      manualBiasPct,
  output logic        [7:0]       excCmdPct,
  output logic                    lockout,
  output logic                    losEvent,
  output logic                    ovxEvent,
  output logic        [18:0]      eventSpn,
  output logic        [4:0]       eventFmi
);
  if (TICK_CYCLES < 2) begin : gBadTick
    $error("TICK_CYCLES too small");
  end

  // ****************************************
  // tick and input synchronisers
  // ****************************************
  logic [31:0] tickCnt_r;
  logic        tick;
  assign tick = (tickCnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tickCnt_r <= 32'h0000_0000;
    else if (tick) tickCnt_r <= 32'h0000_0000;
    else tickCnt_r <= tickCnt_r + 32'h0000_0001;
  end

  logic [3:0] syncA_r, syncB_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_r <= 4'h0;
      syncB_r <= 4'h0;
    end else begin
      syncA_r <= {keyLower, keyRaise, lowerPin, raisePin};
      syncB_r <= syncA_r;
    end
  end
  logic upHeld, dnHeld;
  assign upHeld = (syncB_r[0] | syncB_r[2]) & ~(syncB_r[1] | syncB_r[3]);
  assign dnHeld = (syncB_r[1] | syncB_r[3]) & ~(syncB_r[0] | syncB_r[2]);

  logic engineStopped;
  assign engineStopped = (engineRpm == 16'h0000);

  // ****************************************
  // lockout
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lockout <= vrs_pkg::LOCK_DEF;
    else if (setStopped && engineStopped) lockout <= lockoutReq;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) excCmdPct <= 8'h00;
    else if (lockout) excCmdPct <= 8'h00;
    else excCmdPct <= loopExcPct;
  end

  // ****************************************
  // manual bias
  // ****************************************
  // held press repeats every few ticks; first step lands on the press edge
  logic        held_r;
  logic [3:0]  rptCnt_r;
  logic signed [15:0] manual_nxt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_r   <= 1'b0;
      rptCnt_r <= 4'h0;
    end else begin
      held_r <= upHeld | dnHeld;
      if (!(upHeld | dnHeld) || !held_r) rptCnt_r <= 4'h0;
      else if (tick) rptCnt_r <= (rptCnt_r == 4'(vrs_pkg::REPEAT_TICKS - 1)) ? 4'h0 : rptCnt_r + 4'h1;
    end
  end
  logic stepNow;
  assign stepNow = (upHeld | dnHeld) &&
                   (!held_r || (tick && rptCnt_r == 4'(vrs_pkg::REPEAT_TICKS - 1)));
  always_comb begin
    manual_nxt = manualBiasPct;
    if (stepNow && upHeld) manual_nxt = manualBiasPct + signed'(vrs_pkg::PCT_STEP);
    if (stepNow && dnHeld) manual_nxt = manualBiasPct - signed'(vrs_pkg::PCT_STEP);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) manualBiasPct <= 16'sh0000;
    else if (engineStopped) manualBiasPct <= 16'sh0000;
    else manualBiasPct <= manual_nxt;
  end

  // ****************************************
  // analog bias, total, droop
  // ****************************************
  logic signed [47:0] anaNum;
  logic signed [31:0] anaDen;
  logic signed [15:0] anaBias;
  always_comb begin
    anaNum  = 48'(signed'(anaSig - anaSigLo)) * 48'(signed'(anaDatHi - anaDatLo));
    anaDen  = 32'(signed'(anaSigHi - anaSigLo));
    anaBias = (anaDen == 32'sh0) ? anaDatLo
              : 16'(anaDatLo + 16'(anaNum / 48'(anaDen)));
  end

  logic signed [17:0] biasSum;
  logic signed [15:0] biasClamp;
  always_comb begin
    biasSum   = 18'(manualBiasPct) + 18'(anaBias) + 18'(compBiasPct);
    biasClamp = 16'(biasSum);
    if (biasSum > 18'(signed'({1'b0, maxBiasPct[14:0]}))) biasClamp = signed'({1'b0, maxBiasPct[14:0]});
    if (biasSum < -18'(signed'({1'b0, maxBiasPct[14:0]}))) biasClamp = -signed'({1'b0, maxBiasPct[14:0]});
  end

  // droop = (nominal+bias) * maxDroop * kvar / (full * full); leading kvar is negative
  logic signed [47:0] droopProd;
  logic signed [15:0] droopPct, base;
  always_comb begin
    base      = signed'(vrs_pkg::PCT_FULL) + biasClamp;
    droopProd = 48'(base) * 48'(signed'({1'b0, maxDroopPct[14:0]})) * 48'(kvarPct);
    // divisor kept signed, else a leading (negative) product divides as a huge unsigned value
    droopPct  = 16'(droopProd / signed'(48'(vrs_pkg::PCT_FULL) * 48'(vrs_pkg::PCT_FULL)));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      setpointPct  <= 16'sh0000;
      totalBiasPct <= 16'sh0000;
    end else begin
      setpointPct  <= base - droopPct;
      totalBiasPct <= biasClamp;
    end
  end

  // ****************************************
  // loss of sensing
  // ****************************************
  function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
    absDiff = (a > b) ? a - b : b - a;
  endfunction
  logic senseLost, inhibit, shortCkt;
  always_comb begin
    if (!threePhase) senseLost = vllAvgPct < vrs_pkg::PCT_LOS_LOW;
    else senseLost = (vllAvgPct < vrs_pkg::PCT_LOS_LOW)
                   || absDiff(vllA, vllAvgPct) > vrs_pkg::PCT_LOS_IMB
                   || absDiff(vllB, vllAvgPct) > vrs_pkg::PCT_LOS_IMB
                   || absDiff(vllC, vllAvgPct) > vrs_pkg::PCT_LOS_IMB
                   || vlnA < vrs_pkg::PCT_LOS_LOW || vlnB < vrs_pkg::PCT_LOS_LOW
                   || vlnC < vrs_pkg::PCT_LOS_LOW;
  end
  assign shortCkt = iA > vrs_pkg::PCT_SHORT || iB > vrs_pkg::PCT_SHORT || iC > vrs_pkg::PCT_SHORT;

  // frequency hold-off restarts on each rise above the minimum
  logic       freqAbove_r;
  logic [5:0] freqHold_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freqAbove_r <= 1'b0;
      freqHold_r  <= 6'h00;
    end else begin
      freqAbove_r <= freqHz > minFreqHz;
      if (freqHz > minFreqHz && !freqAbove_r) freqHold_r <= 6'(vrs_pkg::FREQ_TICKS);
      else if (tick && freqHold_r != 6'h00) freqHold_r <= freqHold_r - 6'h01;
    end
  end
  assign inhibit = shortCkt || opMode == vrs_pkg::VRS_SOFT
                   || freqHold_r != 6'h00 || !freqAbove_r || lockout;

  // delay clamped to its documented range
  logic [7:0] losDly, ovxThr, ovxDly;
  assign losDly = (losDelayCfg > vrs_pkg::LOS_DLY_MAX) ? vrs_pkg::LOS_DLY_MAX : losDelayCfg;
  assign ovxThr = (ovxThrCfg < vrs_pkg::OVX_THR_MIN) ? vrs_pkg::OVX_THR_MIN
                  : (ovxThrCfg > vrs_pkg::OVX_THR_DEF) ? vrs_pkg::OVX_THR_DEF : ovxThrCfg;
  assign ovxDly = (ovxDelayCfg < vrs_pkg::OVX_DLY_MIN) ? vrs_pkg::OVX_DLY_MIN
                  : (ovxDelayCfg > vrs_pkg::OVX_DLY_MAX) ? vrs_pkg::OVX_DLY_MAX : ovxDelayCfg;

  logic [7:0] losCnt_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) losCnt_r <= 8'h00;
    else if (!senseLost || inhibit) losCnt_r <= 8'h00;
    else if (tick && losCnt_r < losDly) losCnt_r <= losCnt_r + 8'h01;
  end

  // events latch; a reset in the same cycle as a fresh trigger loses to it
  logic losTrig, ovxTrig;
  assign losTrig = senseLost && !inhibit && losCnt_r >= losDly;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) losEvent <= 1'b0;
    else if (losTrig) losEvent <= 1'b1;
    else if (eventReset) losEvent <= 1'b0;
  end

  // ****************************************
  // over-excitation
  // ****************************************
  logic [7:0] ovxCnt_r;
  logic       ovxHigh;
  assign ovxHigh = excCmdPct > ovxThr;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ovxCnt_r <= 8'h00;
    else if (!ovxHigh) ovxCnt_r <= 8'h00;
    else if (tick && ovxCnt_r <= ovxDly) ovxCnt_r <= ovxCnt_r + 8'h01;
  end
  assign ovxTrig = ovxHigh && ovxCnt_r > ovxDly;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ovxEvent <= 1'b0;
    else if (ovxTrig) ovxEvent <= 1'b1;
    else if (eventReset) ovxEvent <= 1'b0;
  end

  // most recent trigger names the code; sensing loss wins a tie
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eventSpn <= 19'h0_0000;
      eventFmi <= 5'h00;
    end else if (losTrig && !losEvent) begin
      eventSpn <= vrs_pkg::LOS_SPN;
      eventFmi <= vrs_pkg::FMI_ZERO;
    end else if (ovxTrig && !ovxEvent) begin
      eventSpn <= vrs_pkg::OVX_SPN;
      eventFmi <= vrs_pkg::FMI_ZERO;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_lock_zero_exc: assert property (@(posedge clk) disable iff (!reset_n)
    lockout |=> excCmdPct == 8'h00) else $error("exc not zero under lockout");
  chk_lock_change_gate: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(lockout) |-> $past(setStopped) && $past(engineRpm) == 16'h0000)
    else $error("lockout changed while running");
  chk_los_inhibit: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(losEvent) |-> !$past(lockout) && !$past(shortCkt)) else $error("los event while inhibited");
  chk_los_latch: assert property (@(posedge clk) disable iff (!reset_n)
    losEvent && !eventReset |=> losEvent) else $error("los event dropped");
  chk_ovx_latch: assert property (@(posedge clk) disable iff (!reset_n)
    ovxEvent && !eventReset |=> ovxEvent) else $error("ovx event dropped");
  chk_ovx_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(ovxEvent) |-> $past(excCmdPct) > $past(ovxThr)) else $error("ovx without high command");
  chk_manual_clear: assert property (@(posedge clk) disable iff (!reset_n)
    engineStopped |=> manualBiasPct == 16'sh0000) else $error("manual bias kept at stop");
  chk_step_size: assert property (@(posedge clk) disable iff (!reset_n)
    stepNow && upHeld && !engineStopped |=> manualBiasPct == $past(manualBiasPct) + 16'sh0002)
    else $error("wrong step");
  chk_los_code: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(losEvent) |-> eventSpn == vrs_pkg::LOS_SPN) else $error("wrong los code");
  chk_ovx_code: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(ovxEvent) && !$rose(losEvent) |-> eventSpn == vrs_pkg::OVX_SPN)
    else $error("wrong ovx code");
  chk_code_fmi: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(losEvent) || $rose(ovxEvent) |-> eventFmi == vrs_pkg::FMI_ZERO)
    else $error("wrong failure mode");
  // inhibit checks watch the rising edge of the event, since the level stays latched
  chk_los_delay: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(losEvent) |-> $past(losCnt_r) >= $past(losDly))
    else $error("los event before delay");
  chk_los_soft: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(losEvent) |-> $past(opMode) != vrs_pkg::VRS_SOFT)
    else $error("los event during soft start");
  chk_los_freq: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(losEvent) |-> $past(freqHold_r) == 6'h00 && $past(freqAbove_r))
    else $error("los event in frequency hold-off");
  chk_bias_clamp: assert property (@(posedge clk) disable iff (!reset_n)
    biasClamp <= signed'({1'b0, maxBiasPct[14:0]}) && biasClamp >= -signed'({1'b0, maxBiasPct[14:0]}))
    else $error("bias past its limit");
  chk_step_down: assert property (@(posedge clk) disable iff (!reset_n)
    stepNow && dnHeld && !engineStopped |=> manualBiasPct == $past(manualBiasPct) - 16'sh0002)
    else $error("wrong lower step");
  chk_exc_follow: assert property (@(posedge clk) disable iff (!reset_n)
    !lockout |=> excCmdPct == $past(loopExcPct))
    else $error("exc not following loop");
  cov_lockout: cover property (@(posedge clk) disable iff (!reset_n) $rose(lockout));
  cov_los: cover property (@(posedge clk) disable iff (!reset_n) $rose(losEvent));
  cov_ovx: cover property (@(posedge clk) disable iff (!reset_n) $rose(ovxEvent));
  cov_repeat: cover property (@(posedge clk) disable iff (!reset_n) stepNow && held_r);
endmodule
`default_nettype wire

// >>> verilog/vrs_pkg.sv
// package: constants for the voltage regulator supervision block
`default_nettype none
package vrs_pkg;
  // ****************************************
  // fixed-point scales
  // ****************************************
  // percentages are in 0.1 % units, signed 16 bit
  localparam int          PCT_W         = 16;
  localparam logic [15:0] PCT_FULL      = 16'h03E8;   // 100.0 %
  localparam logic [15:0] PCT_LOS_LOW   = 16'h0050;   // 8.0 %
  localparam logic [15:0] PCT_LOS_IMB   = 16'h00C8;   // 20.0 %
  localparam logic [15:0] PCT_SHORT     = 16'h0BB8;   // 300.0 %
  localparam logic [15:0] PCT_STEP      = 16'h0002;   // 0.2 %
  // ****************************************
  // configuration defaults and limits
  // ****************************************
  localparam logic [7:0]  LOS_DLY_DEF   = 8'h14;      // 2.0 s in 0.1 s
  localparam logic [7:0]  LOS_DLY_MAX   = 8'hFA;      // 25.0 s
  localparam logic [7:0]  OVX_THR_DEF   = 8'h64;      // 100 %
  localparam logic [7:0]  OVX_THR_MIN   = 8'h0A;      // 10 %
  localparam logic [7:0]  OVX_DLY_DEF   = 8'h64;      // 10.0 s
  localparam logic [7:0]  OVX_DLY_MIN   = 8'h01;      // 0.1 s
  localparam logic [7:0]  OVX_DLY_MAX   = 8'hC8;      // 20.0 s
  localparam logic        LOCK_DEF      = 1'b0;
  // ****************************************
  // timing
  // ****************************************
  localparam int          CLK_MHZ       = 100;
  localparam int          TICK_MS       = 100;        // one tenth of a second
  localparam int          TICK_CYC      = TICK_MS * 1000 * CLK_MHZ;
  localparam int          REPEAT_MS     = 400;
  localparam int          REPEAT_TICKS  = REPEAT_MS / TICK_MS;
  localparam int          FREQ_HOLD_S   = 5;
  localparam int          FREQ_TICKS    = FREQ_HOLD_S * 1000 / TICK_MS;
  // ****************************************
  // fault code pairs
  // ****************************************
  localparam logic [18:0] LOS_SPN       = 19'h0_0263;  // 611
  localparam logic [18:0] OVX_SPN       = 19'h0_0D35;  // 3381
  localparam logic [4:0]  FMI_ZERO      = 5'h00;
  typedef enum logic [1:0] {VRS_RUN, VRS_SOFT, VRS_LOCK, VRS_STOP} vrs_mode_e;
endpackage
`default_nettype wire

// >>> verification/vrs_gen_model.sv
// partner model: generator sensing voltages and phase currents
`default_nettype none
module vrs_gen_model (
  // scenario control
  input  wire logic [1:0]  senseMode,
  input  wire logic        shortCkt,
  // measurements, 0.1 % of rated
  output logic      [15:0] vllAvgPct,
  output logic      [15:0] vllA,
  output logic      [15:0] vllB,
  output logic      [15:0] vllC,
  output logic      [15:0] vlnA,
  output logic      [15:0] vlnB,
  output logic      [15:0] vlnC,
  output logic      [15:0] iA,
  output logic      [15:0] iB,
  output logic      [15:0] iC
);
  timeunit 1ns;
  timeprecision 1ns;
  // mode 1 drops all sensing, mode 2 loses phase b only, mode 3 sags line b alone (imbalance)
  assign vllAvgPct = (senseMode == 2'h1) ? 16'h0014 : 16'h03E8;
  assign vllA      = vllAvgPct;
  assign vllB      = (senseMode == 2'h3) ? 16'h02BC : vllAvgPct;
  assign vllC      = vllAvgPct;
  assign vlnA      = vllAvgPct;
  assign vlnB      = (senseMode == 2'h1 || senseMode == 2'h2) ? 16'h0014 : 16'h03E8;
  assign vlnC      = vllAvgPct;
  // 310 % on phase a marks a short circuit
  assign iA        = shortCkt ? 16'h0C1C : 16'h01F4;
  assign iB        = 16'h01F4;
  assign iC        = 16'h01F4;
endmodule
`default_nettype wire

// >>> verification/tb_vrs_supervisor.sv
// testbench: self-checking bench for the supervision block
`default_nettype none
module tb_vrs_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int K_SP = 0, K_TB = 1, K_MAN = 2, K_EXC = 3, K_LCK = 4, K_LOS = 5, K_OVX = 6, K_SPN = 7, K_FMI = 8;
  logic               clk, reset_n, threePhase, raisePin, lowerPin, keyRaise, keyLower, shortCkt;
  logic               lockoutReq, setStopped, eventReset, lockout, losEvent, ovxEvent;
  logic signed [15:0] kvarPct, anaSig, anaSigLo, anaSigHi, anaDatLo, anaDatHi, compBiasPct;
  logic signed [15:0] setpointPct, totalBiasPct, manualBiasPct;
  logic        [15:0] vllAvgPct, vllA, vllB, vllC, vlnA, vlnB, vlnC, iA, iB, iC;
  logic        [15:0] freqHz, engineRpm, maxDroopPct, maxBiasPct, minFreqHz;
  logic        [7:0]  loopExcPct, losDelayCfg, ovxThrCfg, ovxDelayCfg, excCmdPct, seed;
  logic        [18:0] eventSpn, got, e19;
  logic        [4:0]  eventFmi;
  logic        [1:0]  senseMode;
  vrs_pkg::vrs_mode_e opMode;
  int                 miscompares, nCompared, k, i;
  int                 kindQ[$];
  logic        [18:0] expQ[$];
  event               chk;
  int                 kvT[7] = '{1000, -1000, 500, 1000, 0, 0, 0};
  int                 cbT[7] = '{0, 0, 0, 100, 300, 0, -300};
  int                 anT[7] = '{0, 0, 0, 0, 0, 2, 0};
  int                 spT[7] = '{950, 1050, 975, 1045, 1200, 1020, 800};
  int                 tbT[7] = '{0, 0, 0, 100, 200, 20, -200};
  // ****************************************
  // design, partner and clock
  // ****************************************
  // ten clocks a tick keeps the 5 s frequency hold at 500 clocks
  vrs_supervisor #(.TICK_CYCLES(10)) dut (
    .clk(clk), .reset_n(reset_n), .kvarPct(kvarPct), .vllAvgPct(vllAvgPct), .vllA(vllA), .vllB(vllB),
    .vllC(vllC), .vlnA(vlnA), .vlnB(vlnB), .vlnC(vlnC), .iA(iA), .iB(iB), .iC(iC), .freqHz(freqHz),
    .engineRpm(engineRpm), .loopExcPct(loopExcPct), .opMode(opMode), .threePhase(threePhase),
    .raisePin(raisePin), .lowerPin(lowerPin), .keyRaise(keyRaise), .keyLower(keyLower),
    .maxDroopPct(maxDroopPct), .maxBiasPct(maxBiasPct), .minFreqHz(minFreqHz), .losDelayCfg(losDelayCfg),
    .ovxThrCfg(ovxThrCfg), .ovxDelayCfg(ovxDelayCfg), .lockoutReq(lockoutReq), .setStopped(setStopped),
    .anaSig(anaSig), .anaSigLo(anaSigLo), .anaSigHi(anaSigHi), .anaDatLo(anaDatLo), .anaDatHi(anaDatHi),
    .compBiasPct(compBiasPct), .eventReset(eventReset), .setpointPct(setpointPct),
    .totalBiasPct(totalBiasPct), .manualBiasPct(manualBiasPct), .excCmdPct(excCmdPct), .lockout(lockout),
    .losEvent(losEvent), .ovxEvent(ovxEvent), .eventSpn(eventSpn), .eventFmi(eventFmi));
  vrs_gen_model gen (.senseMode(senseMode), .shortCkt(shortCkt), .vllAvgPct(vllAvgPct), .vllA(vllA),
    .vllB(vllB), .vllC(vllC), .vlnA(vlnA), .vlnB(vlnB), .vlnC(vlnC), .iA(iA), .iB(iB), .iC(iC));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic note(input int kd, input int ev);
    kindQ.push_back(kd);
    expQ.push_back((kd == K_SPN) ? 19'(ev) : {3'h0, 16'(ev)});
    ->chk;
  endtask
  task automatic clear_events();
    eventReset = 1'b1;
    cyc(2);
    eventReset = 1'b0;
    cyc(2);
  endtask
  task automatic compare(input int kd, input logic [18:0] g, input logic [18:0] x);
    nCompared++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t kind %0d got %h exp %h", $time, kd, g, x);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // result watcher: oldest note against the outputs
  // ****************************************
  always @(chk) begin
    while (kindQ.size() > 0) begin
      k = kindQ.pop_front();
      e19 = expQ.pop_front();
      case (k)
        K_SP:    got = {3'h0, setpointPct};
        K_TB:    got = {3'h0, totalBiasPct};
        K_MAN:   got = {3'h0, manualBiasPct};
        K_EXC:   got = {11'h000, excCmdPct};
        K_LCK:   got = {18'h0_0000, lockout};
        K_LOS:   got = {18'h0_0000, losEvent};
        K_OVX:   got = {18'h0_0000, ovxEvent};
        K_SPN:   got = eventSpn;
        default: got = {14'h0000, eventFmi};
      endcase
      compare(k, got, e19);
    end
  end
  initial begin
    #200_000;
    miscompares++;
    stop_test();
  end
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    reset_n = 1'b0; threePhase = 1'b0; raisePin = 1'b0; lowerPin = 1'b0; keyRaise = 1'b0; keyLower = 1'b0;
    shortCkt = 1'b0; lockoutReq = 1'b0; setStopped = 1'b0; eventReset = 1'b0; senseMode = 2'h0;
    kvarPct = 16'sh0000; anaSig = 16'sh0000; anaSigLo = -16'sh000A; anaSigHi = 16'sh000A;
    anaDatLo = -16'sh0064; anaDatHi = 16'sh0064; compBiasPct = 16'sh0000; freqHz = 16'h0000;
    engineRpm = 16'h05DC; maxDroopPct = 16'h0032; maxBiasPct = 16'h00C8; minFreqHz = 16'h0014;
    losDelayCfg = 8'h03; ovxThrCfg = 8'h50; ovxDelayCfg = 8'h02; loopExcPct = 8'h28;
    opMode = vrs_pkg::VRS_RUN; seed = 8'h3B;
    cyc(20);
    reset_n = 1'b1;
    cyc(3);
    note(K_LCK, 0);
    for (i = 0; i < 7; i++) begin
      kvarPct = 16'(kvT[i]); compBiasPct = 16'(cbT[i]); anaSig = 16'(anT[i]);
      cyc(5);
      note(K_SP, spT[i]);
      note(K_TB, tbT[i]);
    end
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed); loopExcPct = seed;
      cyc(3);
      note(K_EXC, int'(seed));
    end
    loopExcPct = 8'h28;
    raisePin = 1'b1; cyc(5); raisePin = 1'b0; cyc(5);
    note(K_MAN, 2);
    keyLower = 1'b1; cyc(5); keyLower = 1'b0; cyc(5);
    note(K_MAN, 0);
    lowerPin = 1'b1; cyc(60); lowerPin = 1'b0; cyc(5);
    note(K_MAN, -4);
    engineRpm = 16'h0000; cyc(5);
    note(K_MAN, 0);
    freqHz = 16'h003C; senseMode = 2'h1; cyc(300);
    note(K_LOS, 0);
    cyc(300);
    note(K_LOS, 1);
    note(K_SPN, 611);
    note(K_FMI, 0);
    senseMode = 2'h0; cyc(30);
    note(K_LOS, 1);
    clear_events();
    note(K_LOS, 0);
    for (i = 0; i < 2; i++) begin
      shortCkt = (i == 0); opMode = (i == 0) ? vrs_pkg::VRS_RUN : vrs_pkg::VRS_SOFT; senseMode = 2'h1;
      cyc(100);
      note(K_LOS, 0);
      senseMode = 2'h0; cyc(2); shortCkt = 1'b0; opMode = vrs_pkg::VRS_RUN; cyc(2);
    end
    threePhase = 1'b1; senseMode = 2'h2; cyc(100);
    note(K_LOS, 1);
    senseMode = 2'h0; clear_events();
    senseMode = 2'h3; cyc(100);
    note(K_LOS, 1);
    senseMode = 2'h0; clear_events();
    lockoutReq = 1'b1; cyc(3);
    note(K_LCK, 0);
    setStopped = 1'b1; engineRpm = 16'h05DC; cyc(3);
    note(K_LCK, 0);
    engineRpm = 16'h0000; cyc(3);
    note(K_LCK, 1);
    note(K_EXC, 0);
    senseMode = 2'h1; cyc(100);
    note(K_LOS, 0);
    senseMode = 2'h0; lockoutReq = 1'b0; cyc(3);
    note(K_LCK, 0);
    setStopped = 1'b0; loopExcPct = 8'h5A; cyc(15);
    note(K_OVX, 0);
    cyc(60);
    note(K_OVX, 1);
    note(K_SPN, 3381);
    loopExcPct = 8'h28; cyc(2);
    clear_events();
    note(K_OVX, 0);
    cyc(2);
    stop_test();
  end
endmodule
`default_nettype wire
